// File: core/lcs_pkg.sv
// launch cutoff interlock sequencer: shared constants and types
package lcs_pkg;
  // register map, byte addresses
  localparam logic [3:0] LCS_OFF_CTRL = 4'h0;
  localparam logic [3:0] LCS_OFF_STAT = 4'h4;
  localparam int LCS_CTRL_ARM_BIT = 0;
  localparam logic LCS_ARM_RST = 1'b0;
  localparam logic [1:0] LCS_RESP_OK = 2'h0;
  localparam logic [1:0] LCS_RESP_DECERR = 2'h3;
  // timing
  localparam int LCS_CLK_MHZ = 200;
  localparam int LCS_STAGGER_MS = 100;
  localparam int LCS_STAGGER_CYC = LCS_STAGGER_MS * 1000 * LCS_CLK_MHZ;
  // engine groups, bit 0 is engine 1
  localparam logic [4:0] LCS_GRP_NORM = 5'h15;
  localparam logic [4:0] LCS_GRP_ALT = 5'h1a;
  localparam logic [4:0] LCS_ALL_STOP = 5'h1f;
  localparam logic [4:0] LCS_ENG_24 = 5'h0a;
  // cutoff cause bits
  localparam int LCS_C_MAN = 0;
  localparam int LCS_C_LOGIC = 1;
  localparam int LCS_C_FUEL = 2;
  localparam int LCS_C_PSU = 3;
  localparam int LCS_C_VOLT = 4;
  localparam int LCS_C_EMG = 5;
  localparam int LCS_C_FCU = 6;

  typedef enum logic [1:0] {LCS_IDLE, LCS_RUN, LCS_CUT, LCS_DONE} lcs_st_t;

  typedef struct packed {
    logic t187;
    logic tm17;
    logic tm8p9;
    logic tm50ms;
    logic tp6;
    logic umb_sep;
    logic fire_en;
    logic [7:0] prep;
    logic man_cut;
    logic stop_int;
    logic [1:0] destruct_bad;
    logic rcv_bad;
    logic [4:0] valve_a;
    logic [4:0] valve_b;
    logic hyp_rupt;
    logic psu_bad;
    logic main_bus_bad;
    logic instr_bus_bad;
    logic [2:0] crew_cut;
    logic [2:0] vote_ok;
    logic fcu_ready;
  } lcs_pins_t;

  typedef struct packed {
    logic [12:0] rsvd;
    logic [6:0] cause;
    logic [4:0] stop;
    logic alt;
    logic umb;
    logic win_emg;
    logic win_rcv;
    logic done;
    logic cut;
    logic run;
  } lcs_stat_t;

  typedef struct packed {
    lcs_pins_t s1;
    lcs_pins_t s2;
    lcs_pins_t s3;
    lcs_pins_t f;
    lcs_pins_t fp;
    lcs_st_t st;
    logic run;
    logic cut;
    logic done;
    logic [24:0] cnt;
    logic win_rcv;
    logic win_emg;
    logic umb;
    logic alt;
    logic arm;
    logic [4:0] stop;
    logic [6:0] cause;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lcs_state_t;
endpackage

// File: core/lcs_top.sv
// launch cutoff interlock sequencer with axi4-lite registers
module lcs_top
  import lcs_pkg::*;
#(
  parameter int STAGGER_CYC = LCS_STAGGER_CYC
)
(
  // clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  // countdown clock, switches and vehicle sensors
  input wire lcs_pins_t PINS,
  // sequencer outputs
  output logic SEQ_RUN,
  output logic CUTOFF,
  output logic SEQ_DONE,
  output logic [4:0] ENG_STOP,
  // axi4-lite slave
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  function automatic logic [4:0] grp(input logic alt);
    grp = alt ? LCS_GRP_ALT : LCS_GRP_NORM;
  endfunction

  lcs_state_t r;
  lcs_state_t n;
  lcs_pins_t ev;
  lcs_stat_t stat;
  logic prep_all;
  logic start_ok;
  logic [4:0] ff;
  logic [6:0] cz;

  ////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = r;
    ev = r.f & ~r.fp;
    prep_all = &r.f.prep;
    start_ok = ev.t187 & r.arm & prep_all & r.f.fire_en;
    // early open before rupture, or one valve of a pair open
    ff = (r.f.valve_a & r.f.valve_b & {5{~r.f.hyp_rupt}}) | (r.f.valve_a ^ r.f.valve_b);
    cz = '0;
    cz[LCS_C_MAN] = r.f.man_cut & ~r.umb;
    cz[LCS_C_LOGIC] = r.f.stop_int | (|r.f.destruct_bad) | (r.f.rcv_bad & r.win_rcv);
    cz[LCS_C_FUEL] = |ff;
    cz[LCS_C_PSU] = r.f.psu_bad;
    cz[LCS_C_VOLT] = r.f.main_bus_bad | r.f.instr_bus_bad;
    cz[LCS_C_EMG] = r.win_emg & ((|r.f.crew_cut) | ~(&r.f.vote_ok));
    cz[LCS_C_FCU] = r.win_emg & ~r.f.fcu_ready;

    // three-stage pin synchroniser, filtered on stages two and three
    n.s1 = PINS;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f = (r.s2 & r.s3) | (r.f & (r.s2 | r.s3));
    n.fp = r.f;

    // countdown windows
    if (ev.tm17)
      n.win_rcv = 1'b1;
    if (ev.tm8p9)
      n.win_emg = 1'b1;
    if (ev.tm50ms)
    begin
      n.win_rcv = 1'b0;
      n.win_emg = 1'b0;
    end
    if (ev.umb_sep)
      n.umb = 1'b1;

    case (r.st)
      LCS_IDLE:
      begin
        if (start_ok)
          n.st = LCS_RUN;
      end
      LCS_RUN:
      begin
        if (|cz)
        begin
          n.st = LCS_CUT;
          n.cause = cz;
          n.alt = cz[LCS_C_FUEL] & (|(ff & LCS_ENG_24));
          n.stop = grp(n.alt);
          n.cnt = '0;
        end
        else if (ev.tp6)
          n.st = LCS_DONE;
      end
      LCS_CUT:
      begin
        if (r.stop != LCS_ALL_STOP)
        begin
          if (r.cnt == 25'(STAGGER_CYC - 1))
            n.stop = LCS_ALL_STOP;
          else
            n.cnt = r.cnt + 25'h1;
        end
      end
      LCS_DONE:
      begin
        n.st = LCS_DONE;
      end
      default:
      begin
        n.st = LCS_IDLE;
      end
    endcase
    n.run = (n.st == LCS_RUN);
    n.cut = (n.st == LCS_CUT);
    n.done = (n.st == LCS_DONE);

    // write channel: address and data in either order
    if (S_AXI_AWVALID && r.awready)
    begin
      n.aw_have = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && r.wready)
    begin
      n.w_have = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (r.bvalid && S_AXI_BREADY)
      n.bvalid = 1'b0;
    if (r.aw_have && r.w_have && !r.bvalid)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = LCS_RESP_OK;
      if (r.awaddr[3:2] == LCS_OFF_CTRL[3:2])
      begin
        if (r.wstrb[0])
          n.arm = r.wdata[LCS_CTRL_ARM_BIT];
      end
      else if (r.awaddr[3:2] != LCS_OFF_STAT[3:2])
        n.bresp = LCS_RESP_DECERR;
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;

    // read channel
    stat = '0;
    stat.run = r.run;
    stat.cut = r.cut;
    stat.done = r.done;
    stat.win_rcv = r.win_rcv;
    stat.win_emg = r.win_emg;
    stat.umb = r.umb;
    stat.alt = r.alt;
    stat.stop = r.stop;
    stat.cause = r.cause;
    if (r.rvalid && S_AXI_RREADY)
    begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (S_AXI_ARVALID && r.arready)
    begin
      n.rvalid = 1'b1;
      n.arready = 1'b0;
      n.rresp = LCS_RESP_OK;
      n.rdata = '0;
      if (S_AXI_ARADDR[3:2] == LCS_OFF_CTRL[3:2])
        n.rdata[LCS_CTRL_ARM_BIT] = r.arm;
      else if (S_AXI_ARADDR[3:2] == LCS_OFF_STAT[3:2])
        n.rdata = stat;
      else
        n.rresp = LCS_RESP_DECERR;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      r <= '0;
      r.arm <= LCS_ARM_RST;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end
    else if (CE)
      r <= n;
  end

  assign SEQ_RUN = r.run;
  assign CUTOFF = r.cut;
  assign SEQ_DONE = r.done;
  assign ENG_STOP = r.stop;
  assign S_AXI_AWREADY = r.awready;
  assign S_AXI_WREADY = r.wready;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_ARREADY = r.arready;
  assign S_AXI_RVALID = r.rvalid;
  assign S_AXI_RDATA = r.rdata;
  assign S_AXI_RRESP = r.rresp;

  ////////////////////////////////////////////////////////////////////
  // checks
  logic [24:0] hc;
  always_ff @(posedge CLK_SYS)
  begin
    if (RST || !r.cut)
      hc <= '0;
    else if (CE)
      hc <= hc + 25'h1;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_start_gate: assert property ($rose(r.run) |-> $past(start_ok))
    else $error("sequencer started without interlocks");
  a_prep_block: assert property (CE && r.st == LCS_IDLE && !prep_all |=> !r.run)
    else $error("start despite missing preparation");
  a_no_hold: assert property (CE && r.run && cz == '0 && !ev.tp6 |=> r.run)
    else $error("sequence left run without cause");
  a_auto_end: assert property (CE && r.run && cz == '0 && ev.tp6 |=> r.done)
    else $error("sequence did not end at plus mark");
  a_manual_cut: assert property (CE && r.run && r.f.man_cut && !r.umb
    |=> r.cut && r.cause[LCS_C_MAN])
    else $error("manual cutoff not honoured");
  a_auto_cut: assert property (CE && r.run && (|cz[6:1]) |=> r.cut && r.cause[6:1] != 0)
    else $error("automatic interlock ignored");
  a_logic_cut: assert property (CE && r.run && r.f.stop_int |=> r.cause[LCS_C_LOGIC])
    else $error("stage logic cutoff missing");
  a_rcv_window: assert property ($rose(r.cause[LCS_C_LOGIC]) && !$past(r.win_rcv)
    |-> $past(r.f.stop_int || r.f.destruct_bad != 0))
    else $error("receiver check outside window");
  a_fuel_cut: assert property (CE && r.run && ff != 0 |=> r.cause[LCS_C_FUEL])
    else $error("fuel valve cutoff missing");
  a_group_pick: assert property ($rose(r.cut) |-> r.stop == grp(r.alt)
    && r.alt == (r.cause[LCS_C_FUEL] && $past((ff & LCS_ENG_24) != 0)))
    else $error("wrong first shutdown group");
  a_second_grp: assert property ($rose(r.stop == LCS_ALL_STOP) |-> hc == 25'(STAGGER_CYC))
    else $error("second group delay wrong");
  a_supply_cut: assert property (CE && r.run && (r.f.psu_bad || r.f.main_bus_bad)
    |=> r.cut)
    else $error("supply cutoff missing");
  a_bus_cut: assert property (CE && r.run && r.f.instr_bus_bad |=> r.cause[LCS_C_VOLT])
    else $error("bus voltage cutoff missing");
  a_emg_window: assert property ($rose(r.cause[LCS_C_EMG]) |-> $past(r.win_emg))
    else $error("emergency cutoff outside window");
  a_emg_vote: assert property (CE && r.run && r.win_emg && !(&r.f.vote_ok)
    |=> r.cause[LCS_C_EMG])
    else $error("voting bus loss ignored");
  a_fcu_cut: assert property (CE && r.run && r.win_emg && !r.f.fcu_ready
    |=> r.cause[LCS_C_FCU])
    else $error("flight unit loss ignored");
  a_fcu_window: assert property ($rose(r.cause[LCS_C_FCU]) |-> $past(r.win_emg))
    else $error("flight unit cutoff outside window");
  a_cut_latch: assert property (r.cut |=> r.cut && $stable(r.cause))
    else $error("cutoff state not latched");

  c_start: cover property ($rose(r.run));
  c_done: cover property ($rose(r.done));
  c_alt_group: cover property ($rose(r.cut) && r.alt);
  c_full_stop: cover property ($rose(r.stop == LCS_ALL_STOP));
endmodule

// File: verif/lcs_far.sv
// far side model: countdown marks, console switches, vehicle sensors
module lcs_far
  import lcs_pkg::*;
(
  // clock
  input wire logic clk,
  // pins toward the sequencer
  output lcs_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  lcs_pins_t p;
  logic unit_ok;
  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    pins = p;
    pins.fcu_ready = unit_ok;
  end
  task automatic idle();
    p <= '0;
    unit_ok <= 1'b0;
  endtask
  // drop: bit0 arm (bench side), bit1 one prep item, bit2 fire enable
  task automatic ready(input logic [2:0] drop);
    p.fire_en <= !drop[2];
    p.prep <= drop[1] ? 8'hef : 8'hff;
    p.vote_ok <= 3'h7;
    unit_ok <= 1'b1;
  endtask
  // held long enough to pass the input filter
  task automatic mark(input int k);
    p[40 - k] <= 1'b1;
    repeat (6) @(posedge clk);
    p[40 - k] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// File: verif/tb.sv
// self-checking bench for the launch cutoff sequencer
module tb
  import lcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STG = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  lcs_pins_t pins;
  logic seq_run, cutoff, seq_done, bv, awr, wr, arr, rv;
  logic [4:0] stop;
  logic [3:0] awa = 4'h0;
  logic [3:0] ara = 4'h0;
  logic aw = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic ar = 1'b0;
  logic rr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  int error_cnt = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  lcs_far u_far (.clk(clk), .pins(pins));
  lcs_top #(.STAGGER_CYC(STG)) u_dut (.CLK_SYS(clk), .RST(rst), .CE(ce), .PINS(pins),
    .SEQ_RUN(seq_run), .CUTOFF(cutoff), .SEQ_DONE(seq_done), .ENG_STOP(stop),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(aw), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(ar),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ready and valid are sampled mid-cycle, where they are settled
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ta, tw, tb_;
    @(posedge clk);
    awa <= a;
    wd <= d;
    aw <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    tb_ = 1'b0;
    for (int n = 0; n < 50 && !tb_; n++)
    begin
      @(negedge clk);
      ta = aw & awr;
      tw = wv & wr;
      tb_ = bv;
      resp = bresp;
      @(posedge clk);
      if (ta)
        aw <= 1'b0;
      if (tw)
        wv <= 1'b0;
    end
    if (!tb_)
      error_cnt++;
    br <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ta, got;
    @(posedge clk);
    ara <= a;
    ar <= 1'b1;
    rr <= 1'b1;
    got = 1'b0;
    for (int n = 0; n < 50 && !got; n++)
    begin
      @(negedge clk);
      ta = ar & arr;
      got = rv;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta)
        ar <= 1'b0;
    end
    if (!got)
      error_cnt++;
    rr <= 1'b0;
  endtask
  task automatic reset_dut();
    @(posedge clk);
    rst <= 1'b1;
    u_far.idle();
    cyc(10);
    rst <= 1'b0;
    cyc(2);
  endtask
  task automatic go(input logic [2:0] drop);
    logic [1:0] r;
    reset_dut();
    axw(LCS_OFF_CTRL, {31'h0, !drop[0]}, r);
    u_far.ready(drop);
    cyc(2);
    u_far.mark(0);
  endtask
  task automatic cut_seen(input logic [6:0] cause, input logic [4:0] grp);
    logic [31:0] d;
    logic [1:0] r;
    for (int n = 0; n < 20 && cutoff !== 1'b1; n++)
      @(negedge clk);
    chk(cutoff, 1);
    chk(stop, grp);
    chk(seq_run, 0);
    @(posedge clk);
    u_far.idle();
    cyc(STG + 2);
    chk(stop, LCS_ALL_STOP);
    chk(cutoff, 1);
    axr(LCS_OFF_STAT, d, r);
    chk(d[18:12], cause);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    reset_dut();
    chk({seq_run, cutoff, seq_done, stop}, 0);
    axw(LCS_OFF_CTRL, 32'h1, r);
    axr(LCS_OFF_CTRL, d, r);
    chk(d, 1);
    axw(4'h8, 32'h1, r);
    chk(r, LCS_RESP_DECERR);
    axr(4'h8, d, r);
    chk(r, LCS_RESP_DECERR);
    chk(d, 0);
    axw(LCS_OFF_STAT, 32'hffffffff, r);
    chk(r, LCS_RESP_OK);
    axr(LCS_OFF_STAT, d, r);
    chk(d, 0);
    $display("test reset done");
  endtask
  task automatic t_block();
    for (int k = 0; k < 3; k++)
    begin
      go(3'h1 << k);
      cyc(8);
      chk(seq_run, 0);
    end
    $display("test start interlocks done");
  endtask
  task automatic t_cause();
    logic [6:0] exp [5] = '{7'h08, 7'h10, 7'h10, 7'h02, 7'h02};
    for (int k = 0; k < 5; k++)
    begin
      go(3'h0);
      chk(seq_run, 1);
      case (k)
        0: u_far.p.psu_bad <= 1'b1;
        1: u_far.p.main_bus_bad <= 1'b1;
        2: u_far.p.instr_bus_bad <= 1'b1;
        3: u_far.p.stop_int <= 1'b1;
        default: u_far.p.destruct_bad <= 2'h2;
      endcase
      cut_seen(exp[k], LCS_GRP_NORM);
    end
    $display("test causes done");
  endtask
  task automatic t_fuel();
    for (int k = 0; k < 6; k++)
    begin
      go(3'h0);
      u_far.p.valve_a[k % 5] <= 1'b1;
      if (k == 5)
        u_far.p.valve_b[0] <= 1'b1;
      cut_seen(7'h04, (k == 1 || k == 3) ? LCS_GRP_ALT : LCS_GRP_NORM);
    end
    // both valves open after rupture is legal, then a pair mismatch
    go(3'h0);
    u_far.p.hyp_rupt <= 1'b1;
    u_far.p.valve_a[2] <= 1'b1;
    u_far.p.valve_b[2] <= 1'b1;
    cyc(10);
    chk(cutoff, 0);
    u_far.p.valve_b[2] <= 1'b0;
    cut_seen(7'h04, LCS_GRP_NORM);
    $display("test fuel valves done");
  endtask
  task automatic t_win();
    logic [6:0] exp [4] = '{7'h20, 7'h20, 7'h40, 7'h02};
    for (int k = 0; k < 4; k++)
    begin
      go(3'h0);
      case (k)
        0: u_far.p.crew_cut <= 3'h4;
        1: u_far.p.vote_ok <= 3'h6;
        2: u_far.unit_ok <= 1'b0;
        default: u_far.p.rcv_bad <= 1'b1;
      endcase
      cyc(10);
      chk(cutoff, 0);
      u_far.mark(k == 3 ? 1 : 2);
      cut_seen(exp[k], LCS_GRP_NORM);
    end
    // windows closed again after the late mark
    go(3'h0);
    u_far.mark(1);
    u_far.mark(2);
    u_far.mark(3);
    u_far.p.crew_cut <= 3'h1;
    u_far.p.rcv_bad <= 1'b1;
    u_far.unit_ok <= 1'b0;
    cyc(10);
    chk(cutoff, 0);
    u_far.p.man_cut <= 1'b1;
    cut_seen(7'h01, LCS_GRP_NORM);
    $display("test windows done");
  endtask
  task automatic t_man();
    go(3'h0);
    // clock enable low freezes the pin path and the sequencer
    ce <= 1'b0;
    u_far.p.man_cut <= 1'b1;
    cyc(10);
    chk(cutoff, 0);
    ce <= 1'b1;
    cut_seen(7'h01, LCS_GRP_NORM);
    go(3'h0);
    u_far.mark(5);
    u_far.p.man_cut <= 1'b1;
    cyc(10);
    chk(cutoff, 0);
    u_far.mark(4);
    chk(seq_done, 1);
    chk(seq_run, 0);
    $display("test manual cutoff and completion done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    u_far.idle();
    t_reset();
    t_block();
    t_cause();
    t_fuel();
    t_win();
    t_man();
    stop_test();
  end
  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule
